/* File: irq_pkg.sv */
// Purpose: Shared constants, types and helpers of the vectored interrupt handler.
// Assumes: 22 sources, APB register access, one 125 MHz clock.
// Notes:   Offsets are APB byte addresses.
package irq_pkg;

    localparam int          NUM_SRC   = 22;
    localparam int          IDX_W     = 5;
    localparam int          EXT_PINS  = 10;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFF_PRIMARY_EN   = 8'h00;
    localparam logic [7:0]  OFF_EXT_EN_ONE   = 8'h04;
    localparam logic [7:0]  OFF_EXT_EN_TWO   = 8'h08;
    localparam logic [7:0]  OFF_PRIMARY_PRI  = 8'h0C;
    localparam logic [7:0]  OFF_EXT_PRI_ONE  = 8'h10;
    localparam logic [7:0]  OFF_EXT_PRI_TWO  = 8'h14;
    localparam logic [7:0]  OFF_PEND         = 8'h18;
    localparam logic [7:0]  OFF_PEND_SET     = 8'h1C;
    localparam logic [7:0]  OFF_PEND_CLR     = 8'h20;
    localparam logic [7:0]  OFF_IRQ_STAT     = 8'h24;
    localparam logic [7:0]  OFF_IRQ_MASK     = 8'h28;
    localparam logic [7:0]  OFF_SVC_STAT     = 8'h2C;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          GIE_BIT          = 7;
    localparam int          PRIMARY_SRCS     = 6;
    localparam int          EXT_ONE_BASE     = 6;
    localparam int          EXT_TWO_BASE     = 14;
    localparam int          STAT_TAKEN_BIT   = 0;
    localparam int          STAT_RETURN_BIT  = 1;
    localparam int          STAT_W           = 2;
    localparam logic [NUM_SRC-1:0] EN_RESET  = 22'h00_0000;
    localparam logic [NUM_SRC-1:0] PRI_RESET = 22'h00_0000;
    localparam logic [STAT_W-1:0]  STAT_RESET = 2'h0;

    // Sources whose pending flag the handler clears when the call is made.
    localparam logic [NUM_SRC-1:0] HW_CLR_MASK  = 22'h0F_0005;
    // Sources that may be driven from the external interrupt pins.
    localparam logic [NUM_SRC-1:0] EXT_SRC_MASK = 22'h0F_3C05;

    // ------------------------------------------------------------------
    // Vectors and timing
    // ------------------------------------------------------------------
    localparam logic [15:0] VEC_BASE   = 16'h0003;
    localparam logic [15:0] VEC_STEP   = 16'h0008;
    localparam int          LONG_CALL_INSTR_CYC  = 4;

    typedef struct packed {
        logic               req;
        logic               hi;
        logic [IDX_W-1:0]   idx;
        logic [15:0]        vector;
    } call_t;

    function automatic logic [15:0] vec_of(input logic [IDX_W-1:0] idx);
        logic [15:0] v;
        v = VEC_BASE + {idx, 3'b000};
        return v;
    endfunction : vec_of

    // Lowest index set wins; the fixed order runs from source 0 upward.
    function automatic logic [IDX_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (v[i])
                r = IDX_W'(i);
        end
        return r;
    endfunction : first_set

endpackage : irq_pkg

/* File: pin_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs change slowly compared with mclk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,    // system clock
    input  wire logic             rstn,    // synchronous reset, active low
    input  wire logic [WIDTH-1:0] async_i, // raw pin levels
    output logic      [WIDTH-1:0] sync_o   // levels in the mclk domain
);
    logic [WIDTH-1:0] meta_q;

    // Pins idle high, so reset to ones to avoid a false falling edge.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            meta_q <= '1;
            sync_o <= '1;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : pin_sync
`default_nettype wire

/* File: prio_pick.sv */
// Purpose: Two-level priority choice among eligible interrupt requests.
// Assumes: Request vectors are already gated by enables and service state.
// Notes:   Purely combinational.
`timescale 1ns/1ns
`default_nettype none
module prio_pick
    import irq_pkg::*;
(
    input  wire logic [NUM_SRC-1:0] req_hi, // eligible high-level requests
    input  wire logic [NUM_SRC-1:0] req_lo, // eligible low-level requests
    output logic                    found,  // some request is eligible
    output logic                    hi,     // chosen request is high level
    output logic [IDX_W-1:0]        idx     // chosen source index
);
    always_comb
    begin
        found = |req_hi || |req_lo;
        hi    = |req_hi;
        idx   = (|req_hi) ? first_set(req_hi) : first_set(req_lo);
    end
endmodule : prio_pick
`default_nettype wire

/* File: irq_ctrl.sv */
// Purpose: Vectored interrupt handler: pending flags, enables, priority and long-call vectoring.
// Assumes: The sequencer pulses instr_done at each instruction end and return_from_irq_instr_done at return.
// Notes:   Registers are reached over APB with one wait state per access.
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl
    import irq_pkg::*;
(
    input  wire logic                mclk,       // system clock, 125 MHz
    input  wire logic                rstn,       // synchronous reset, active low
    input  wire logic [NUM_SRC-1:0]  src_set,    // peripheral event pulses
    input  wire logic [EXT_PINS-1:0] ext_irq_n,  // external pins, falling edge
    input  wire logic                instr_done, // current instruction completes
    input  wire logic                return_from_irq_instr_done,  // return instruction completes
    input  wire logic                psel,       // APB select
    input  wire logic                penable,    // APB enable
    input  wire logic                pwrite,     // APB direction
    input  wire logic [7:0]          paddr,      // APB byte address
    input  wire logic [31:0]         pwdata,     // APB write data
    output logic                     pready,     // APB ready
    output logic [31:0]              prdata,     // APB read data
    output logic                     pslverr,    // APB error
    output call_t                    call,       // long-call request to sequencer
    output logic                     irq         // status interrupt, level
);
    typedef enum logic [0:0] {ST_IDLE, ST_CALL} state_t;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [NUM_SRC-1:0]  en_q;
    logic                gie_q;
    logic [NUM_SRC-1:0]  pri_q;
    logic [NUM_SRC-1:0]  pend_q;
    logic [STAT_W-1:0]   stat_q;
    logic [STAT_W-1:0]   mask_q;
    logic                svc_hi_q;
    logic                svc_lo_q;
    logic                skip_q;
    logic [1:0]          cnt_q;
    state_t              state_q;
    logic [EXT_PINS-1:0] pin_s;
    logic [EXT_PINS-1:0] pin_prev_q;

    // ------------------------------------------------------------------
    // External pins
    // ------------------------------------------------------------------
    pin_sync #(.WIDTH(EXT_PINS)) u_sync (
        .mclk    (mclk),
        .rstn    (rstn),
        .async_i (ext_irq_n),
        .sync_o  (pin_s)
    );

    always_ff @(posedge mclk)
    begin
        if (!rstn)
            pin_prev_q <= '1;
        else
            pin_prev_q <= pin_s;
    end

    // Pins fan out, in order, to the source slots that the mask marks.
    logic [NUM_SRC-1:0] pin_ev;
    always_comb
    begin
        int k;
        k = 0;
        pin_ev = '0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (EXT_SRC_MASK[i] && k < EXT_PINS)
            begin
                pin_ev[i] = pin_prev_q[k] & ~pin_s[k];
                k = k + 1;
            end
        end
    end

    // ------------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------------
    logic acc_fire;
    logic wr_fire;
    logic rd_fire;
    assign acc_fire = psel && penable && pready;
    assign wr_fire  = acc_fire && pwrite;
    assign rd_fire  = acc_fire && !pwrite;

    function automatic logic mapped(input logic [7:0] a);
        return a == OFF_PRIMARY_EN || a == OFF_EXT_EN_ONE || a == OFF_EXT_EN_TWO
            || a == OFF_PRIMARY_PRI || a == OFF_EXT_PRI_ONE || a == OFF_EXT_PRI_TWO
            || a == OFF_PEND || a == OFF_PEND_SET || a == OFF_PEND_CLR
            || a == OFF_IRQ_STAT || a == OFF_IRQ_MASK || a == OFF_SVC_STAT;
    endfunction : mapped

    // Source bits spread over three registers: six, eight and eight wide.
    function automatic logic [31:0] slice(input logic [NUM_SRC-1:0] v, input int grp);
        logic [31:0] r;
        r = '0;
        if (grp == 0)
            r[PRIMARY_SRCS-1:0] = v[PRIMARY_SRCS-1:0];
        else if (grp == 1)
            r[7:0] = v[EXT_TWO_BASE-1:EXT_ONE_BASE];
        else
            r[7:0] = v[NUM_SRC-1:EXT_TWO_BASE];
        return r;
    endfunction : slice

    function automatic logic [NUM_SRC-1:0] merge(input logic [NUM_SRC-1:0] v,
                                                 input logic [31:0] d, input int grp);
        logic [NUM_SRC-1:0] r;
        r = v;
        if (grp == 0)
            r[PRIMARY_SRCS-1:0] = d[PRIMARY_SRCS-1:0];
        else if (grp == 1)
            r[EXT_TWO_BASE-1:EXT_ONE_BASE] = d[7:0];
        else
            r[NUM_SRC-1:EXT_TWO_BASE] = d[7:0];
        return r;
    endfunction : merge

    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = '0;
        case (paddr)
            OFF_PRIMARY_EN:
            begin
                rd_val          = slice(en_q, 0);
                rd_val[GIE_BIT] = gie_q;
            end
            OFF_EXT_EN_ONE:  rd_val = slice(en_q, 1);
            OFF_EXT_EN_TWO:  rd_val = slice(en_q, 2);
            OFF_PRIMARY_PRI: rd_val = slice(pri_q, 0);
            OFF_EXT_PRI_ONE: rd_val = slice(pri_q, 1);
            OFF_EXT_PRI_TWO: rd_val = slice(pri_q, 2);
            OFF_PEND:        rd_val[NUM_SRC-1:0] = pend_q;
            OFF_IRQ_STAT:    rd_val[STAT_W-1:0] = stat_q;
            OFF_IRQ_MASK:    rd_val[STAT_W-1:0] = mask_q;
            OFF_SVC_STAT:    rd_val[IDX_W+2:0] = {svc_hi_q, svc_lo_q, skip_q, call.idx};
            default:         rd_val = '0;
        endcase
    end

    // One wait state: ready rises at the end of the first access cycle, so the
    // transfer completes on the second access edge.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end
        else if (psel && penable && !pready)
        begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr <= !mapped(paddr);
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            en_q   <= EN_RESET;
            gie_q  <= 1'b0;
            pri_q  <= PRI_RESET;
            mask_q <= STAT_RESET;
        end
        else if (wr_fire)
        begin
            case (paddr)
                OFF_PRIMARY_EN:
                begin
                    en_q  <= merge(en_q, pwdata, 0);
                    gie_q <= pwdata[GIE_BIT];
                end
                OFF_EXT_EN_ONE:  en_q   <= merge(en_q, pwdata, 1);
                OFF_EXT_EN_TWO:  en_q   <= merge(en_q, pwdata, 2);
                OFF_PRIMARY_PRI: pri_q  <= merge(pri_q, pwdata, 0);
                OFF_EXT_PRI_ONE: pri_q  <= merge(pri_q, pwdata, 1);
                OFF_EXT_PRI_TWO: pri_q  <= merge(pri_q, pwdata, 2);
                OFF_IRQ_MASK:    mask_q <= pwdata[STAT_W-1:0];
                default:         mask_q <= mask_q;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------------
    logic               call_end;
    logic [NUM_SRC-1:0] hw_set;
    logic [NUM_SRC-1:0] sw_set;
    logic [NUM_SRC-1:0] clr;
    always_comb
    begin
        hw_set = src_set | pin_ev;
        sw_set = (wr_fire && paddr == OFF_PEND_SET) ? pwdata[NUM_SRC-1:0] : '0;
        clr    = (wr_fire && paddr == OFF_PEND_CLR) ? pwdata[NUM_SRC-1:0] : '0;
        if (call_end && HW_CLR_MASK[call.idx])
            clr[call.idx] = 1'b1;
    end

    // Any set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            pend_q <= '0;
        else
            pend_q <= (pend_q & ~clr) | hw_set | sw_set;
    end

    // ------------------------------------------------------------------
    // Eligibility and choice
    // ------------------------------------------------------------------
    logic [NUM_SRC-1:0] act;
    logic [NUM_SRC-1:0] req_hi;
    logic [NUM_SRC-1:0] req_lo;
    logic               pick_found;
    logic               pick_hi;
    logic [IDX_W-1:0]   pick_idx;
    logic               dec_take;

    always_comb
    begin
        act    = gie_q ? (pend_q & en_q) : '0;
        req_hi = svc_hi_q ? '0 : (act & pri_q);
        req_lo = (svc_hi_q || svc_lo_q) ? '0 : (act & ~pri_q);
    end

    prio_pick u_pick (
        .req_hi (req_hi),
        .req_lo (req_lo),
        .found  (pick_found),
        .hi     (pick_hi),
        .idx    (pick_idx)
    );

    // The choice is taken only at an instruction end and never on the
    // first instruction end after a return.
    assign dec_take = (state_q == ST_IDLE) && instr_done && !skip_q && pick_found;
    assign call_end = (state_q == ST_CALL) && (cnt_q == 2'(LONG_CALL_INSTR_CYC - 1));

    // ------------------------------------------------------------------
    // Call sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            call    <= '0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= '0;
                    if (dec_take)
                    begin
                        // Vector is frozen here and held for the whole call.
                        state_q     <= ST_CALL;
                        call.req    <= 1'b1;
                        call.hi     <= pick_hi;
                        call.idx    <= pick_idx;
                        call.vector <= vec_of(pick_idx);
                    end
                end
                ST_CALL:
                begin
                    cnt_q <= cnt_q + 2'd1;
                    if (call_end)
                    begin
                        state_q  <= ST_IDLE;
                        call.req <= 1'b0;
                    end
                end
                default:
                begin
                    state_q  <= ST_IDLE;
                    call.req <= 1'b0;
                end
            endcase
        end
    end

    // Service levels: a return closes the innermost level, high first.
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            svc_hi_q <= 1'b0;
            svc_lo_q <= 1'b0;
        end
        else if (call_end)
        begin
            if (call.hi)
                svc_hi_q <= 1'b1;
            else
                svc_lo_q <= 1'b1;
        end
        else if (return_from_irq_instr_done)
        begin
            if (svc_hi_q)
                svc_hi_q <= 1'b0;
            else
                svc_lo_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
            skip_q <= 1'b0;
        else if (return_from_irq_instr_done)
            skip_q <= 1'b1;
        else if (instr_done)
            skip_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Status interrupt
    // ------------------------------------------------------------------
    logic [STAT_W-1:0] ev;
    always_comb
    begin
        ev                  = '0;
        ev[STAT_TAKEN_BIT]  = call_end;
        ev[STAT_RETURN_BIT] = return_from_irq_instr_done;
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            stat_q <= STAT_RESET;
            irq    <= 1'b0;
        end
        else
        begin
            // Only the bits handed out by this read are cleared; an event that
            // lands after the read data was latched survives for the next read.
            stat_q <= ((rd_fire && paddr == OFF_IRQ_STAT)
                       ? (stat_q & ~prdata[STAT_W-1:0]) : stat_q) | ev;
            irq    <= |(stat_q & mask_q);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_call_hold;
        call.req [*4] ##1 !call.req;
    endsequence

    sequence s_take;
        dec_take ##1 call.req;
    endsequence

    AST_CALL_LEN: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(call.req) |-> s_call_hold)
        else $error("Long call did not last four cycles.");
    AST_GLOBAL_BLOCK: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(call.req) |-> $past(gie_q))
        else $error("Call started with global enable clear.");
    AST_VEC_STABLE: assert property (@(posedge mclk) disable iff (!rstn)
        call.req && $past(call.req) |-> $stable(call.vector))
        else $error("Vector changed during the call.");
    AST_VECTOR: assert property (@(posedge mclk) disable iff (!rstn)
        s_take |-> call.vector == vec_of($past(pick_idx)))
        else $error("Wrong vector for chosen source.");
    AST_SET_WINS: assert property (@(posedge mclk) disable iff (!rstn)
        |hw_set |=> (pend_q & $past(hw_set)) == $past(hw_set))
        else $error("Hardware event lost.");
    AST_HI_KEEP: assert property (@(posedge mclk) disable iff (!rstn)
        svc_hi_q && $past(svc_hi_q) |-> !$rose(call.req))
        else $error("High level service preempted.");
    AST_RETURN_FROM_IRQ_INSTR_ONE: assert property (@(posedge mclk) disable iff (!rstn)
        skip_q && instr_done |=> !$rose(call.req))
        else $error("Re-entry without one further instruction.");
    AST_PRIO: assert property (@(posedge mclk) disable iff (!rstn)
        dec_take && |req_hi |=> call.hi)
        else $error("Low level chosen over high level.");
    AST_HW_CLR: assert property (@(posedge mclk) disable iff (!rstn)
        call_end && HW_CLR_MASK[call.idx] && !hw_set[call.idx] && !sw_set[call.idx]
        |=> !pend_q[$past(call.idx)])
        else $error("Auto-clear flag not cleared at vectoring.");
    AST_IRQ: assert property (@(posedge mclk) disable iff (!rstn)
        |(stat_q & mask_q) |=> irq)
        else $error("Interrupt output missing.");

endmodule : irq_ctrl
`default_nettype wire

/* File: seq_model.sv */
// Purpose: Instruction sequencer stand-in facing the interrupt handler.
// Assumes: Outside a long call an instruction ends every fourth clock.
// Notes:   A return completes one clock after ret_go.
`timescale 1ns/1ns
`default_nettype none
module seq_model
    import irq_pkg::*;
(
    input  wire logic  mclk,       // system clock
    input  wire logic  rstn,       // synchronous reset, active low
    input  wire call_t call,       // long-call request
    input  wire logic  ret_go,     // run a return now
    output logic       instr_done, // instruction end pulse
    output logic       return_from_irq_instr_done   // return end pulse
);
    logic [1:0] cnt_q;
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            cnt_q      <= 2'h0;
            instr_done <= 1'b0;
            return_from_irq_instr_done  <= 1'b0;
        end
        else
        begin
            // No instruction can end while the long call owns the sequencer.
            cnt_q      <= call.req ? 2'h0 : cnt_q + 2'h1;
            instr_done <= !call.req && cnt_q == 2'h3;
            return_from_irq_instr_done  <= ret_go;
        end
    end
endmodule : seq_model
`default_nettype wire

/* File: test_vectored_interrupt_handler.sv */
// Purpose: Self-checking bench of the interrupt handler.
// Assumes: Handler answers APB with one wait state.
// Notes:   External pins idle high; one scenario pulls a pin low.
`timescale 1ns/1ns
`default_nettype none
module test_vectored_interrupt_handler;
    import irq_pkg::*;
    logic               mclk, rstn, psel, penable, pwrite, pready, pslverr;
    logic               instr_done, return_from_irq_instr_done, irq, ret_go, err;
    logic [NUM_SRC-1:0] src_set;
    logic [EXT_PINS-1:0] ext_irq_n;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd;
    call_t              call;
    int                 fails, compares, cyc;

    irq_ctrl irq_ctrl_i (.mclk, .rstn, .src_set, .ext_irq_n,
        .instr_done, .return_from_irq_instr_done, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .call, .irq);
    seq_model seq_model_i (.mclk, .rstn, .call, .ret_go, .instr_done, .return_from_irq_instr_done);

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // A hung wait must still reach the verdict.
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            fails++;
            end_of_test();
        end
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task end_of_test;
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task rc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, e, rd);
    endtask : rc
    task ret;
        ret_go <= 1'b1;
        @(posedge mclk);
        ret_go <= 1'b0;
        @(posedge mclk);
    endtask : ret
    task wait_call(input int i, input logic h);
        int n;
        n = 0;
        while (call.req !== 1'b1 && n < 60)
        begin
            @(posedge mclk);
            n++;
        end
        chk("vector", VEC_BASE + VEC_STEP * 16'(i), 32'(call.vector));
        chk("level", 32'(h), 32'(call.hi));
        n = 0;
        while (call.req === 1'b1)
        begin
            @(posedge mclk);
            n++;
        end
        chk("call length", 32'(LONG_CALL_INSTR_CYC), 32'(n));
    endtask : wait_call
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset;
        rc("priority", OFF_PRIMARY_PRI, 32'h0000_0000);
        rc("unmapped", 8'h3C, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, 32'(err));
    endtask : t_reset
    task t_blocked;
        apb(1'b1, OFF_PRIMARY_EN, 32'h0000_0001);
        src_set <= 22'h00_0001;
        ext_irq_n <= 10'h3FD;
        @(posedge mclk);
        src_set <= '0;
        repeat (12) @(posedge mclk);
        chk("no call", 32'h0000_0000, 32'(call.req));
        rc("pending", OFF_PEND, 32'h0000_0005);
        ext_irq_n <= '1;
        apb(1'b1, OFF_PEND_CLR, 32'h0000_0004);
    endtask : t_blocked
    task t_vector;
        apb(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
        apb(1'b1, OFF_PRIMARY_EN, 32'h0000_0081);
        wait_call(0, 1'b0);
        rc("pending", OFF_PEND, 32'h0000_0000);
        chk("irq", 32'h0000_0001, 32'(irq));
        rc("status", OFF_IRQ_STAT, 32'h0000_0001);
        rc("status", OFF_IRQ_STAT, 32'h0000_0000);
        chk("irq", 32'h0000_0000, 32'(irq));
        ret();
        rc("enable", OFF_PRIMARY_EN, 32'h0000_0081);
    endtask : t_vector
    task t_soft;
        apb(1'b1, OFF_PRIMARY_EN, 32'h0000_0083);
        apb(1'b1, OFF_PEND_SET, 32'h0000_0002);
        wait_call(1, 1'b0);
        rc("pending", OFF_PEND, 32'h0000_0002);
        ret();
        wait_call(1, 1'b0);
        apb(1'b1, OFF_PEND_CLR, 32'h0000_0002);
        ret();
        rc("pending", OFF_PEND, 32'h0000_0000);
    endtask : t_soft
    task t_prio;
        apb(1'b1, OFF_PRIMARY_PRI, 32'h0000_0010);
        apb(1'b1, OFF_PRIMARY_EN, 32'h0000_0098);
        src_set <= 22'h00_0018;
        @(posedge mclk);
        src_set <= '0;
        wait_call(4, 1'b1);
        apb(1'b1, OFF_PEND_CLR, 32'h0000_0010);
        ret();
        wait_call(3, 1'b0);
        apb(1'b1, OFF_PEND_SET, 32'h0000_0010);
        wait_call(4, 1'b1);
        apb(1'b1, OFF_PEND_CLR, 32'h0000_0018);
        ret();
        ret();
        rc("pending", OFF_PEND, 32'h0000_0000);
    endtask : t_prio
    task t_ext;
        apb(1'b1, OFF_EXT_PRI_TWO, 32'h0000_0080);
        apb(1'b1, OFF_EXT_EN_TWO, 32'h0000_0080);
        rc("enable", OFF_EXT_EN_TWO, 32'h0000_0080);
        apb(1'b1, OFF_PEND_SET, 32'h0020_0000);
        wait_call(21, 1'b1);
        apb(1'b1, OFF_PEND_CLR, 32'h0020_0000);
        ret();
        rc("status", OFF_IRQ_STAT, 32'h0000_0003);
    endtask : t_ext

    initial
    begin
        {rstn, psel, penable, pwrite, ret_go} = 5'h00;
        {fails, compares, cyc} = 0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        src_set = '0;
        ext_irq_n = '1;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_blocked();
        t_vector();
        t_soft();
        t_prio();
        t_ext();
        end_of_test();
    end
endmodule : test_vectored_interrupt_handler
`default_nettype wire
